// File: src/sirq_map.svh
// register offsets, field positions, reset values and target codes for the sensor irq and indirect access bank
// Operation
// - Masked rising sensor status edges latch a bit in rising-edge status.
// - Masked falling sensor status edges latch a bit in falling-edge status.
// - Rising mask register is read/write and resets to zero.
// - Falling mask exists per receive port; port select picks the copy.
// - Read-only 8-bit reference clock frequency in MHz, reset zero.
// - Target select bits 5:2 route indirect accesses; unlisted codes reserved.
// - Select code 0110 writes both receive ports together.
// - Auto-increment adds one to offset after each indirect access.
// - With read enable, offset write issues read strobe to target.
// - Read enable plus auto-increment: data read strobes next offset.
// - Offset register holds 8-bit register offset within target.
// - Data write writes target register; data read returns target value.
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH
// =====================================================================
// register offsets
`define SIRQ_ADDR_RISE_MASK   8'h7e
`define SIRQ_ADDR_FALL_MASK   8'h7f
`define SIRQ_ADDR_SPARE_A_LO  8'ha0
`define SIRQ_ADDR_SPARE_A_HI  8'ha4
`define SIRQ_ADDR_REFCLK      8'ha5
`define SIRQ_ADDR_SPARE_B_LO  8'ha7
`define SIRQ_ADDR_SPARE_B_HI  8'haf
`define SIRQ_ADDR_IA_CTL      8'hb0
`define SIRQ_ADDR_IA_OFFSET   8'hb1
`define SIRQ_ADDR_INDIRECT_DATA_BYTE     8'hb2
// =====================================================================
// control fields and resets
`define SIRQ_CTL_READ_BIT     0
`define SIRQ_CTL_AUTO_BIT     1
`define SIRQ_CTL_SEL_LSB      2
`define SIRQ_CTL_SEL_MSB      5
`define SIRQ_CTL_WMASK        8'h3f
`define SIRQ_RST_BYTE         8'h00
`define SIRQ_OFFSET_STEP      8'h01
`define SIRQ_PORT_COUNT       2
// =====================================================================
// target select codes
`define SIRQ_TGT_PATGEN       4'h0
`define SIRQ_TGT_RX0          4'h1
`define SIRQ_TGT_RX1          4'h2
`define SIRQ_TGT_RX_SHARED    4'h5
`define SIRQ_TGT_RX_BOTH      4'h6
`define SIRQ_TGT_CSI          4'h7
`endif

// File: src/sirq_pkg.sv
// types shared by the sensor irq and indirect access bank
package sirq_pkg;
    typedef logic [7:0] sirq_byte_type;
    typedef enum logic [1:0] {
        SIRQ_ACC_IDLE  = 2'b00,
        SIRQ_ACC_WRITE = 2'b01,
        SIRQ_ACC_READ  = 2'b10
    } sirq_acc_type;
endpackage

// File: src/sirq_edge_latch.sv
// one status byte: edge detect against last sample, mask, sticky latch
module sirq_edge_latch
    import sirq_pkg::*;
#(
    parameter bit RISING = 1'b1
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // sensor side, already synchronised
    input  wire sirq_byte_type status_now,
    input  wire sirq_byte_type status_prev,
    input  wire sirq_byte_type edge_mask,
    // software clear, one cycle, ones clear
    input  wire sirq_byte_type clear_bits,
    // latched result
    output sirq_byte_type      latched
);
    sirq_byte_type edge_hit;

    assign edge_hit = RISING ? (status_now & ~status_prev & edge_mask)
                             : (~status_now & status_prev & edge_mask);

    // a new edge in the clearing cycle survives: set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latched <= '0;
        end else begin
            latched <= (latched & ~clear_bits) | edge_hit;
        end
    end
endmodule

// File: src/sirq_regs.sv
// sensor edge interrupt masks, reference clock reading and indirect access window
`include "sirq_map.svh"
module sirq_regs
    import sirq_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // register port from the serial host controller, one-cycle strobes
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire sirq_byte_type reg_addr,
    input  wire sirq_byte_type reg_wdata,
    output sirq_byte_type      reg_rdata,
    // port select from the port-select register, one bit per receive port
    input  wire logic [1:0]    port_select,
    // asynchronous inputs
    input  wire sirq_byte_type sensor_status_word,
    input  wire sirq_byte_type ref_clock_frequency_mhz,
    // software clears of the latched status, ones clear
    input  wire sirq_byte_type rise_clear,
    input  wire sirq_byte_type fall_clear,
    output sirq_byte_type      sensor_rise_latched_status,
    output sirq_byte_type      sensor_fall_latched_status,
    output logic               sensor_irq,
    // indirect target bus
    output logic [3:0]         ind_target,
    output sirq_byte_type      ind_offset,
    output sirq_byte_type      ind_wdata,
    output logic               ind_wr_strobe,
    output logic               ind_rd_strobe,
    output logic [1:0]         ind_rx_write_mask,
    input  wire sirq_byte_type ind_rdata
);
    // =====================================================================
    // synchronisers
    sirq_byte_type sens_s1_q, sens_s2_q, sens_prev_q;
    sirq_byte_type freq_s1_q, freq_s2_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sens_s1_q   <= '0;
            sens_s2_q   <= '0;
            sens_prev_q <= '0;
        end else begin
            sens_s1_q   <= sensor_status_word;
            sens_s2_q   <= sens_s1_q;
            sens_prev_q <= sens_s2_q;
        end
    end

    // bytes are sampled bitwise; a changing reading may tear, hence the double read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_s1_q <= `SIRQ_RST_BYTE;
            freq_s2_q <= `SIRQ_RST_BYTE;
        end else begin
            freq_s1_q <= ref_clock_frequency_mhz;
            freq_s2_q <= freq_s1_q;
        end
    end

    // =====================================================================
    // masks
    sirq_byte_type rise_mask_q;
    sirq_byte_type fall_mask_q [`SIRQ_PORT_COUNT];
    sirq_byte_type fall_mask_eff;
    sirq_byte_type fall_mask_rd;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_mask_q <= `SIRQ_RST_BYTE;
        end else if (reg_wr && reg_addr == `SIRQ_ADDR_RISE_MASK) begin
            rise_mask_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int p = 0; p < `SIRQ_PORT_COUNT; p++) begin
                fall_mask_q[p] <= `SIRQ_RST_BYTE;
            end
        end else if (reg_wr && reg_addr == `SIRQ_ADDR_FALL_MASK) begin
            for (int p = 0; p < `SIRQ_PORT_COUNT; p++) begin
                if (port_select[p]) begin
                    fall_mask_q[p] <= reg_wdata;
                end
            end
        end
    end

    // one sensor status word, so either port's enabled mask arms the falling detector
    assign fall_mask_eff = fall_mask_q[0] | fall_mask_q[1];
    // reads return the lowest selected port's copy
    assign fall_mask_rd  = port_select[0] ? fall_mask_q[0] : fall_mask_q[1];

    // =====================================================================
    // edge latches
    sirq_edge_latch #(
        .RISING (1'b1)
    ) u_rise (
        .clk         (clk),
        .rst_b       (rst_b),
        .status_now  (sens_s2_q),
        .status_prev (sens_prev_q),
        .edge_mask   (rise_mask_q),
        .clear_bits  (rise_clear),
        .latched     (sensor_rise_latched_status)
    );

    sirq_edge_latch #(
        .RISING (1'b0)
    ) u_fall (
        .clk         (clk),
        .rst_b       (rst_b),
        .status_now  (sens_s2_q),
        .status_prev (sens_prev_q),
        .edge_mask   (fall_mask_eff),
        .clear_bits  (fall_clear),
        .latched     (sensor_fall_latched_status)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sensor_irq <= 1'b0;
        end else begin
            sensor_irq <= |{sensor_rise_latched_status, sensor_fall_latched_status};
        end
    end

    // =====================================================================
    // indirect access
    sirq_byte_type ctl_q;
    sirq_byte_type offset_q;
    sirq_byte_type offset_d;
    sirq_byte_type tgt_offset_q;
    sirq_byte_type data_q;
    sirq_acc_type  acc_q;
    logic          auto_inc;
    logic          read_en;
    logic          wr_ctl, wr_off, wr_data, rd_data;
    logic [3:0]    sel;

    assign auto_inc = ctl_q[`SIRQ_CTL_AUTO_BIT];
    assign read_en  = ctl_q[`SIRQ_CTL_READ_BIT];
    assign sel      = ctl_q[`SIRQ_CTL_SEL_MSB:`SIRQ_CTL_SEL_LSB];
    assign wr_ctl   = reg_wr && reg_addr == `SIRQ_ADDR_IA_CTL;
    assign wr_off   = reg_wr && reg_addr == `SIRQ_ADDR_IA_OFFSET;
    assign wr_data  = reg_wr && reg_addr == `SIRQ_ADDR_INDIRECT_DATA_BYTE;
    assign rd_data  = reg_rd && reg_addr == `SIRQ_ADDR_INDIRECT_DATA_BYTE;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= `SIRQ_RST_BYTE;
        end else if (wr_ctl) begin
            ctl_q <= reg_wdata & `SIRQ_CTL_WMASK;
        end
    end

    always_comb begin
        offset_d = offset_q;
        if (wr_off) begin
            offset_d = reg_wdata;
        end else if (auto_inc && (wr_data || rd_data)) begin
            offset_d = offset_q + `SIRQ_OFFSET_STEP;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            offset_q <= `SIRQ_RST_BYTE;
        end else begin
            offset_q <= offset_d;
        end
    end

    // the write strobe comes a cycle late, so the target keeps the offset the write aimed at
    // while the host copy has already stepped; a data read right after a data write sees that offset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_offset_q <= `SIRQ_RST_BYTE;
        end else begin
            tgt_offset_q <= wr_data ? offset_q : offset_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_q <= `SIRQ_RST_BYTE;
            acc_q  <= SIRQ_ACC_IDLE;
        end else begin
            if (wr_data) begin
                data_q <= reg_wdata;
            end
            case (1'b1)
                wr_data:                      acc_q <= SIRQ_ACC_WRITE;
                wr_off && read_en:            acc_q <= SIRQ_ACC_READ;
                rd_data && read_en && auto_inc: acc_q <= SIRQ_ACC_READ;
                default:                      acc_q <= SIRQ_ACC_IDLE;
            endcase
        end
    end

    // strobes fire the cycle after the access
    always_comb begin
        ind_wr_strobe = 1'b0;
        ind_rd_strobe = 1'b0;
        case (acc_q)
            SIRQ_ACC_WRITE: ind_wr_strobe = 1'b1;
            SIRQ_ACC_READ:  ind_rd_strobe = 1'b1;
            default: begin
                ind_wr_strobe = 1'b0;
                ind_rd_strobe = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (sel)
            `SIRQ_TGT_RX0:      ind_rx_write_mask = 2'b01;
            `SIRQ_TGT_RX1:      ind_rx_write_mask = 2'b10;
            `SIRQ_TGT_RX_BOTH:  ind_rx_write_mask = 2'b11;
            default:            ind_rx_write_mask = 2'b00;
        endcase
    end

    assign ind_target = sel;
    assign ind_offset = tgt_offset_q;
    assign ind_wdata  = data_q;

    // =====================================================================
    // read mux, registered one cycle after reg_rd
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `SIRQ_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `SIRQ_ADDR_RISE_MASK: reg_rdata <= rise_mask_q;
                `SIRQ_ADDR_FALL_MASK: reg_rdata <= fall_mask_rd;
                `SIRQ_ADDR_REFCLK:    reg_rdata <= freq_s2_q;
                `SIRQ_ADDR_IA_CTL:    reg_rdata <= ctl_q;
                `SIRQ_ADDR_IA_OFFSET: reg_rdata <= offset_q;
                `SIRQ_ADDR_INDIRECT_DATA_BYTE:   reg_rdata <= ind_rdata;
                default:              reg_rdata <= `SIRQ_RST_BYTE;
            endcase
        end
    end
endmodule

// File: verification/sirq_regs_chk.sv
// assertion checker for the sensor irq and indirect access bank
module sirq_regs_chk
    import sirq_pkg::*;
(
    // clock, reset and host port
    input wire logic          clk,
    input wire logic          rst_b,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire sirq_byte_type reg_addr,
    input wire sirq_byte_type reg_wdata,
    input wire sirq_byte_type reg_rdata,
    // sensor interrupt side
    input wire sirq_byte_type rise_clear,
    input wire sirq_byte_type sensor_rise_latched_status,
    input wire sirq_byte_type sensor_fall_latched_status,
    input wire logic          sensor_irq,
    // indirect target bus
    input wire logic [3:0]    ind_target,
    input wire sirq_byte_type ind_offset,
    input wire sirq_byte_type ind_wdata,
    input wire logic          ind_rd_strobe,
    input wire logic          ind_wr_strobe,
    input wire logic [1:0]    ind_rx_write_mask,
    input wire sirq_byte_type ind_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // =====
    // shadow of the control byte, kept here so the checks need no internal probes
    sirq_byte_type ctl_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            ctl_q <= 8'h00;
        else if (reg_wr && reg_addr == 8'hb0)
            ctl_q <= reg_wdata;
    end
    sequence s_data_wr; reg_wr && reg_addr == 8'hb2; endsequence
    sequence s_data_rd; reg_rd && reg_addr == 8'hb2; endsequence
    sequence s_offs_wr; reg_wr && reg_addr == 8'hb1; endsequence
    // =====
    // assertions
    a_data_write: assert property (s_data_wr |=> ind_wr_strobe && ind_wdata == $past(reg_wdata))
        else $error("data write not passed to target");
    a_data_read: assert property (s_data_rd |=> reg_rdata == $past(ind_rdata))
        else $error("data read lost target value");
    a_auto_step: assert property (s_data_rd ##0 ctl_q[1] |=> ind_offset == $past(ind_offset) + 8'h01)
        else $error("offset not stepped after read");
    a_read_chain: assert property (s_data_rd ##0 ctl_q[1:0] == 2'b11 |=> ind_rd_strobe)
        else $error("no follow-up read strobe");
    a_prefetch_strobe: assert property (s_offs_wr ##0 ctl_q[0] |=> ind_rd_strobe && ind_offset == $past(reg_wdata))
        else $error("no prefetch strobe at new offset");
    a_rx_decode: assert property (ind_rx_write_mask == (ind_target == 4'h6 ? 2'b11 : {ind_target == 4'h2, ind_target == 4'h1}))
        else $error("receive port write mask wrong");
    a_target_sel: assert property (reg_wr && reg_addr == 8'hb0 |=> ind_target == ctl_q[5:2])
        else $error("target select not taken");
    a_irq_level: assert property (1'b1 |=> sensor_irq == ($past(sensor_rise_latched_status) != 8'h00 || $past(sensor_fall_latched_status) != 8'h00))
        else $error("interrupt output wrong");
    a_rise_sticky: assert property (($past(sensor_rise_latched_status) & ~$past(rise_clear) & ~sensor_rise_latched_status) == 8'h00)
        else $error("latched bit lost without clear");
endmodule

// File: verification/sirq_target_model.sv
// indirect target blocks: one byte array per select code
module sirq_target_model
    import sirq_pkg::*;
(
    // clock and indirect bus
    input wire logic          clk,
    input wire logic [3:0]    ind_target,
    input wire sirq_byte_type ind_offset,
    input wire sirq_byte_type ind_wdata,
    input wire logic          ind_wr_strobe,
    input wire logic          ind_rd_strobe,
    input wire logic [1:0]    ind_rx_write_mask,
    output sirq_byte_type     ind_rdata,
    output int                rd_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    sirq_byte_type mem [16][256];
    initial rd_cnt = 0;
    assign ind_rdata = mem[ind_target][ind_offset];
    always @(posedge clk) begin
        if (ind_wr_strobe) begin
            mem[ind_target][ind_offset] <= ind_wdata;
            if (ind_rx_write_mask[0]) mem[1][ind_offset] <= ind_wdata;
            if (ind_rx_write_mask[1]) mem[2][ind_offset] <= ind_wdata;
        end
        if (ind_rd_strobe) rd_cnt <= rd_cnt + 1;
    end
endmodule

// File: verification/tb_sirq_regs.sv
// self-checking bench for the sensor irq and indirect access bank
module tb_sirq_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import sirq_pkg::*;
    logic          clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic          sensor_irq, ind_wr_strobe, ind_rd_strobe;
    logic [1:0]    port_select = 2'b01, ind_rx_write_mask;
    logic [3:0]    ind_target;
    sirq_byte_type reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ind_offset, ind_wdata, ind_rdata;
    sirq_byte_type sensor_status_word = 8'h00, ref_clock_frequency_mhz = 8'h00;
    sirq_byte_type rise_clear = 8'h00, fall_clear = 8'h00;
    sirq_byte_type sensor_rise_latched_status, sensor_fall_latched_status, a, d, m, f, v, r;
    sirq_byte_type rsv [5] = '{8'ha0, 8'ha4, 8'ha7, 8'haf, 8'hc0};
    logic [3:0]    codes [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7};
    int            error_cnt = 0, checks = 0, seed = 63030, rd_cnt, i;

    always #25 clk = ~clk;
    sirq_regs u_dut (
        .clk                        (clk),
        .rst_b                      (rst_b),
        .reg_wr                     (reg_wr),
        .reg_rd                     (reg_rd),
        .reg_addr                   (reg_addr),
        .reg_wdata                  (reg_wdata),
        .reg_rdata                  (reg_rdata),
        .port_select                (port_select),
        .sensor_status_word         (sensor_status_word),
        .ref_clock_frequency_mhz    (ref_clock_frequency_mhz),
        .rise_clear                 (rise_clear),
        .fall_clear                 (fall_clear),
        .sensor_rise_latched_status (sensor_rise_latched_status),
        .sensor_fall_latched_status (sensor_fall_latched_status),
        .sensor_irq                 (sensor_irq),
        .ind_target                 (ind_target),
        .ind_offset                 (ind_offset),
        .ind_wdata                  (ind_wdata),
        .ind_wr_strobe              (ind_wr_strobe),
        .ind_rd_strobe              (ind_rd_strobe),
        .ind_rx_write_mask          (ind_rx_write_mask),
        .ind_rdata                  (ind_rdata)
    );
    sirq_target_model u_tgt (
        .clk               (clk),
        .ind_target        (ind_target),
        .ind_offset        (ind_offset),
        .ind_wdata         (ind_wdata),
        .ind_wr_strobe     (ind_wr_strobe),
        .ind_rd_strobe     (ind_rd_strobe),
        .ind_rx_write_mask (ind_rx_write_mask),
        .ind_rdata         (ind_rdata),
        .rd_cnt            (rd_cnt)
    );

    // =====
    // helpers
    function automatic sirq_byte_type rnd();
        return sirq_byte_type'($random(seed));
    endfunction
    function automatic sirq_byte_type ctl(input logic [3:0] c, input logic ai, input logic re);
        return {2'b00, c, ai, re};
    endfunction
    task automatic chk(input sirq_byte_type got, input sirq_byte_type exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input sirq_byte_type ad, input sirq_byte_type dt);
        @(posedge clk);
        #5;
        reg_addr = ad;
        reg_wdata = dt;
        reg_wr = 1'b1;
        @(posedge clk);
        #5;
        reg_wr = 1'b0;
    endtask
    task automatic rd_reg(input sirq_byte_type ad, output sirq_byte_type dt);
        @(posedge clk);
        #5;
        reg_addr = ad;
        reg_rd = 1'b1;
        @(posedge clk);
        #5;
        reg_rd = 1'b0;
        dt = reg_rdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // =====
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #5;
        rst_b = 1'b1;
        rd_reg(8'h7e, r);
        chk(r, 8'h00);
        rd_reg(8'ha5, r);
        chk(r, 8'h00);
        for (i = 0; i < 4; i++) begin
            m = rnd();
            wr_reg(8'h7e, m);
            rd_reg(8'h7e, r);
            chk(r, m);
        end
        f = rnd();
        wr_reg(8'h7f, f);
        port_select = 2'b10;
        wr_reg(8'h7f, ~f);
        rd_reg(8'h7f, r);
        chk(r, ~f);
        port_select = 2'b01;
        rd_reg(8'h7f, r);
        chk(r, f);
        foreach (rsv[k]) begin
            wr_reg(rsv[k], 8'hff);
            rd_reg(rsv[k], r);
            chk(r, 8'h00);
        end
        wr_reg(8'hb0, 8'hff);
        rd_reg(8'hb0, r);
        chk(r, 8'h3f);
        ref_clock_frequency_mhz = rnd();
        repeat (3) @(posedge clk);
        rd_reg(8'ha5, r);
        rd_reg(8'ha5, d);
        chk(r, d);
        chk(r, ref_clock_frequency_mhz);
        $display("register map test done");
        // =====
        // edge interrupts
        m = rnd() | 8'h01;
        f = rnd() | 8'h01;
        v = rnd() | 8'h01;
        wr_reg(8'h7e, m);
        port_select = 2'b11;
        wr_reg(8'h7f, f);
        sensor_status_word = v;
        repeat (5) @(posedge clk);
        #5;
        chk(sensor_rise_latched_status, v & m);
        chk({7'h00, sensor_irq}, 8'h01);
        sensor_status_word = 8'h00;
        repeat (5) @(posedge clk);
        #5;
        chk(sensor_rise_latched_status, v & m);
        chk(sensor_fall_latched_status, v & f);
        rise_clear = 8'hff;
        fall_clear = 8'hff;
        @(posedge clk);
        #5;
        rise_clear = 8'h00;
        fall_clear = 8'h00;
        repeat (2) @(posedge clk);
        #5;
        chk(sensor_rise_latched_status | sensor_fall_latched_status, 8'h00);
        chk({7'h00, sensor_irq}, 8'h00);
        $display("edge interrupt test done");
        // =====
        // indirect window, every listed target code
        foreach (codes[j]) begin
            a = rnd();
            d = rnd();
            wr_reg(8'hb0, ctl(codes[j], 1'b1, 1'b0));
            wr_reg(8'hb1, a);
            wr_reg(8'hb2, d);
            wr_reg(8'hb2, ~d);
            rd_reg(8'hb1, r);
            chk(r, a + 8'h02);
            wr_reg(8'hb1, a + 8'h01);
            rd_reg(8'hb2, r);
            chk(r, ~d);
        end
        wr_reg(8'hb0, ctl(4'h6, 1'b0, 1'b0));
        wr_reg(8'hb1, a);
        wr_reg(8'hb2, d);
        for (i = 1; i < 3; i++) begin
            wr_reg(8'hb0, ctl(i[3:0], 1'b0, 1'b0));
            rd_reg(8'hb2, r);
            chk(r, d);
        end
        i = rd_cnt;
        wr_reg(8'hb0, ctl(4'h1, 1'b1, 1'b1));
        wr_reg(8'hb1, a);
        rd_reg(8'hb2, r);
        rd_reg(8'hb2, r);
        rd_reg(8'hb1, r);
        chk(r, a + 8'h02);
        chk(sirq_byte_type'(rd_cnt - i), 8'h03);
        $display("indirect window test done");
        wrap_up();
    end
endmodule

bind sirq_regs sirq_regs_chk u_chk (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .rise_clear, .sensor_rise_latched_status, .sensor_fall_latched_status, .sensor_irq, .ind_target,
    .ind_offset, .ind_wdata, .ind_rd_strobe, .ind_wr_strobe, .ind_rx_write_mask, .ind_rdata);
